// ===== design/srdma_dev.sv
// terminal end: requests the host bus and sequences single and burst transfers
`default_nettype none
module srdma_dev (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // link
    srdma_if.dev link,
    // job request
    input wire logic job_valid_i,
    output logic job_ready_o,
    input wire logic job_burst_i,
    input wire logic [srdma_pkg::CNT_W-1:0] job_reads_i,
    input wire logic [srdma_pkg::CNT_W-1:0] job_writes_i,
    input wire logic [srdma_pkg::ADDR_W-1:0] job_addr_i,
    input wire srdma_pkg::srdma_mode_t mode_i,
    input wire logic buffered_i,
    // strap pin, low selects 8-bit shared ram
    input wire logic narrow_ram_select_n_i,
    // write words
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic [srdma_pkg::DATA_W-1:0] wr_data_i,
    // read words and status
    output logic rd_valid_o,
    output logic [srdma_pkg::DATA_W-1:0] rd_data_o,
    output logic done_o,
    output logic err_o
);
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_REQ = 5'h02,
        S_ACK = 5'h04,
        S_XFER = 5'h08,
        S_INT = 5'h10
    } srdma_state_t;

    localparam int IW = srdma_pkg::CNT_W + 1;

    srdma_state_t state_q;
    logic [2:0] narrow_sync_q;
    logic narrow_q;
    logic [IW-1:0] reads_q;
    logic [IW-1:0] total_q;
    logic [IW-1:0] idx_q;
    logic [3:0] cyc_q;
    logic [srdma_pkg::ADDR_W-1:0] base_q;
    logic req_n_q;
    logic ack_n_q;
    logic sel_n_q;
    logic wr_n_q;
    logic [srdma_pkg::ADDR_W-1:0] addr_q;
    logic [srdma_pkg::DATA_W-1:0] wdata_q;
    logic fifo_valid;
    logic fifo_pop;
    logic [srdma_pkg::DATA_W-1:0] fifo_data;

    // ------------------------------------------------------------
    // write data buffer
    // ------------------------------------------------------------
    srdma_fifo #(
        .WIDTH(srdma_pkg::DATA_W),
        .DEPTH(srdma_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(wr_valid_i),
        .in_ready_o(wr_ready_o),
        .in_data_i(wr_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data)
    );

    // ------------------------------------------------------------
    // transfer decode
    // ------------------------------------------------------------
    function automatic logic [3:0] xfer_len(input logic first, input logic narrow_int);
        if (narrow_int) begin
            return srdma_pkg::NARROW_XFER_CYC;
        end
        return first ? srdma_pkg::FIRST_XFER_CYC : srdma_pkg::NEXT_XFER_CYC;
    endfunction

    wire in_idle = (state_q == S_IDLE);
    wire word_mon = (mode_i == srdma_pkg::SRDMA_MODE_WORD_MON);
    wire job_bad = job_burst_i && word_mon;
    wire job_take = job_valid_i && in_idle && !job_bad;
    // reads come first, writes after them
    wire is_write = (idx_q >= reads_q);
    wire narrow_int = narrow_q && !link.mem_select_in_n;
    wire [3:0] len = xfer_len(idx_q == '0, narrow_int);
    wire stall = (cyc_q == 4'h0) && is_write && !fifo_valid;
    wire xfer_end = (cyc_q == len - 4'h1);
    wire last_xfer = (idx_q == total_q - IW'(1));
    wire xfer_start = (state_q == S_XFER) && (cyc_q == 4'h0) && !stall;
    wire [IW-1:0] job_reads = job_burst_i ? IW'(job_reads_i) : IW'(job_writes_i == '0);
    wire [IW-1:0] job_total = job_burst_i ? IW'(job_reads_i) + IW'(job_writes_i) : IW'(1);

    assign fifo_pop = xfer_start && is_write;
    assign link.transfer_request_n = req_n_q;
    assign link.transfer_ack_n = ack_n_q;
    assign link.mem_select_out_n = sel_n_q;
    assign link.io_strobe_n = sel_n_q;
    assign link.write_n = wr_n_q;
    assign link.addr = addr_q;
    assign link.wdata = wdata_q;

    // ------------------------------------------------------------
    // strap synchroniser
    // ------------------------------------------------------------
    // change counts once the second and third stages agree
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            narrow_sync_q <= 3'h7;
            narrow_q <= 1'b0;
        end else begin
            narrow_sync_q <= {narrow_sync_q[1:0], narrow_ram_select_n_i};
            if (narrow_sync_q[1] == narrow_sync_q[2]) begin
                narrow_q <= !narrow_sync_q[2];
            end
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= S_IDLE;
            reads_q <= '0;
            total_q <= '0;
            idx_q <= '0;
            cyc_q <= '0;
            base_q <= '0;
            req_n_q <= 1'b1;
            ack_n_q <= 1'b1;
            sel_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            addr_q <= '0;
            wdata_q <= '0;
            job_ready_o <= 1'b0;
            rd_valid_o <= 1'b0;
            rd_data_o <= '0;
            done_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            rd_valid_o <= 1'b0;
            done_o <= 1'b0;
            err_o <= job_valid_i && in_idle && job_bad;
            unique case (state_q)
                S_IDLE: begin
                    job_ready_o <= 1'b1;
                    if (job_take) begin
                        job_ready_o <= 1'b0;
                        reads_q <= job_reads;
                        total_q <= job_total;
                        base_q <= job_addr_i;
                        idx_q <= '0;
                        cyc_q <= '0;
                        if (job_total == '0) begin
                            done_o <= 1'b1;
                            job_ready_o <= 1'b1;
                        end else if (buffered_i) begin
                            // buffered transfers stay inside, link stays quiet
                            state_q <= S_INT;
                        end else begin
                            req_n_q <= 1'b0;
                            state_q <= S_REQ;
                        end
                    end
                end
                S_REQ: begin
                    // request held until the grant is seen
                    if (!link.transfer_grant_n) begin
                        ack_n_q <= 1'b0;
                        state_q <= S_ACK;
                    end
                end
                S_ACK: begin
                    state_q <= S_XFER;
                end
                S_XFER: begin
                    if (!stall) begin
                        cyc_q <= xfer_end ? 4'h0 : cyc_q + 4'h1;
                    end
                    if (xfer_start) begin
                        sel_n_q <= 1'b0;
                        wr_n_q <= !is_write;
                        addr_q <= base_q + srdma_pkg::ADDR_W'(idx_q);
                        if (is_write) begin
                            wdata_q <= fifo_data;
                        end
                    end
                    if (!stall && xfer_end) begin
                        sel_n_q <= 1'b1;
                        wr_n_q <= 1'b1;
                        idx_q <= idx_q + IW'(1);
                        if (!is_write) begin
                            rd_valid_o <= 1'b1;
                            rd_data_o <= link.rdata;
                        end
                        if (last_xfer) begin
                            req_n_q <= 1'b1;
                            ack_n_q <= 1'b1;
                            done_o <= 1'b1;
                            job_ready_o <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_INT: begin
                    // internal path not modelled: every word paced at NEXT_XFER_CYC, first included, no link traffic
                    cyc_q <= (cyc_q == srdma_pkg::NEXT_XFER_CYC - 4'h1) ? 4'h0 : cyc_q + 4'h1;
                    if (cyc_q == srdma_pkg::NEXT_XFER_CYC - 4'h1) begin
                        idx_q <= idx_q + IW'(1);
                        if (last_xfer) begin
                            done_o <= 1'b1;
                            job_ready_o <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== design/srdma_pkg.sv
// shared constants for the shared ram transfer sequencer and its host end
`default_nettype none
package srdma_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    localparam int CNT_W = 4;
    localparam int FIFO_DEPTH = 32;
    // per-transfer clock counts
    localparam logic [3:0] FIRST_XFER_CYC = 4'h5;
    localparam logic [3:0] NEXT_XFER_CYC = 4'h4;
    localparam logic [3:0] NARROW_XFER_CYC = 4'h8;
    // longest request to grant wait, 16-bit memory at 10 MHz
    localparam real CLK_MHZ = 10.0;
    localparam real GRANT_MAX_US = 3.1;
    localparam int GRANT_MAX_CYC = int'($floor(GRANT_MAX_US * CLK_MHZ));
    // words of device-internal ram seen by the host decoder
    localparam logic [15:0] INT_RAM_WORDS = 16'h1000;
    // terminal operating modes
    typedef enum logic [1:0] {
        SRDMA_MODE_BC = 2'h0,
        SRDMA_MODE_RT = 2'h1,
        SRDMA_MODE_MSG_MON = 2'h2,
        SRDMA_MODE_WORD_MON = 2'h3
    } srdma_mode_t;
endpackage
`default_nettype wire

// ===== design/srdma_if.sv
// link between the terminal's transfer sequencer and the host bus owner
`default_nettype none
interface srdma_if;
    logic transfer_request_n;
    logic transfer_grant_n;
    logic transfer_ack_n;
    logic mem_select_out_n;
    logic mem_select_in_n;
    logic io_strobe_n;
    logic write_n;
    logic [srdma_pkg::ADDR_W-1:0] addr;
    logic [srdma_pkg::DATA_W-1:0] wdata;
    logic [srdma_pkg::DATA_W-1:0] rdata;

    modport dev (
        output transfer_request_n, transfer_ack_n, mem_select_out_n, io_strobe_n,
        output write_n, addr, wdata,
        input transfer_grant_n, mem_select_in_n, rdata
    );
    modport host (
        input transfer_request_n, transfer_ack_n, mem_select_out_n, io_strobe_n,
        input write_n, addr, wdata,
        output transfer_grant_n, mem_select_in_n, rdata
    );
endinterface
`default_nettype wire

// ===== design/srdma_fifo.sv
// flip-flop fifo with registered valid and ready
`default_nettype none
module srdma_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;

    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data_o = mem_q[rd_ptr_q];

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    // flags come from the next count so both stay honest with a flop output
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
            in_ready_o <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
            rd_ptr_q <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
            cnt_q <= cnt_d;
            in_ready_o <= (cnt_d != FULL_CNT);
            out_valid_o <= (cnt_d != '0);
        end
    end
endmodule
`default_nettype wire

// ===== design/srdma_host.sv
// host end: grants the shared bus and decodes internal or external ram
`default_nettype none
module srdma_host (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // link
    srdma_if.host link,
    // host bus state and options
    input wire logic bus_busy_i,
    input wire logic use_io_strobe_i,
    // external memory port and late grant flag
    output logic [srdma_pkg::ADDR_W-1:0] mem_addr_o,
    output logic [srdma_pkg::DATA_W-1:0] mem_wdata_o,
    output logic mem_we_o,
    output logic mem_re_o,
    input wire logic [srdma_pkg::DATA_W-1:0] mem_rdata_i,
    output logic grant_late_o
);
    logic grant_n_q;
    logic msel_in_n_q;
    logic strobe_n_prev_q;
    logic [7:0] wait_q;
    logic [srdma_pkg::DATA_W-1:0] rdata_q;

    // without a select output, ack and io strobe both low form the equivalent;
    // gating the low levels the other way would hold it low for a whole burst
    wire strobe_n = use_io_strobe_i ? (link.transfer_ack_n | link.io_strobe_n)
                                    : link.mem_select_out_n;
    wire internal_hit = !strobe_n && (link.addr < srdma_pkg::INT_RAM_WORDS);
    wire strobe_start = !strobe_n && strobe_n_prev_q;
    wire pending = !link.transfer_request_n && grant_n_q;
    wire wait_over = (wait_q >= 8'(srdma_pkg::GRANT_MAX_CYC - 2));

    assign link.transfer_grant_n = grant_n_q;
    assign link.mem_select_in_n = msel_in_n_q;
    assign link.rdata = rdata_q;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            grant_n_q <= 1'b1;
            msel_in_n_q <= 1'b1;
            strobe_n_prev_q <= 1'b1;
            wait_q <= '0;
            rdata_q <= '0;
            mem_addr_o <= '0;
            mem_wdata_o <= '0;
            mem_we_o <= 1'b0;
            mem_re_o <= 1'b0;
            grant_late_o <= 1'b0;
        end else begin
            // grant only on a free bus, but never later than the latency limit
            if (link.transfer_request_n) begin
                grant_n_q <= 1'b1;
            end else if (pending && (!bus_busy_i || wait_over)) begin
                grant_n_q <= 1'b0;
            end
            wait_q <= pending ? wait_q + 8'h01 : 8'h00;
            grant_late_o <= pending && bus_busy_i && wait_over;
            msel_in_n_q <= !internal_hit;
            strobe_n_prev_q <= strobe_n;
            mem_we_o <= strobe_start && !internal_hit && !link.write_n;
            mem_re_o <= strobe_start && !internal_hit && link.write_n;
            if (strobe_start) begin
                mem_addr_o <= link.addr;
                mem_wdata_o <= link.wdata;
            end
            rdata_q <= mem_rdata_i;
        end
    end
endmodule
`default_nettype wire

// ===== dv/srdma_chk.sv
// link checker for the transfer sequencer and host ends
`default_nettype none
module srdma_chk (
    // clock, reset and strap
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic narrow_ram_select_n_i,
    // link
    input wire logic transfer_request_n,
    input wire logic transfer_grant_n,
    input wire logic transfer_ack_n,
    input wire logic mem_select_out_n,
    input wire logic mem_select_in_n,
    input wire logic io_strobe_n,
    input wire logic write_n,
    input wire logic [srdma_pkg::ADDR_W-1:0] addr
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    localparam int GRANT_LIM = srdma_pkg::GRANT_MAX_CYC;
    logic wrote_q;
    logic wrote_d;
    // set once a burst has written; a later read would break read-before-write
    assign wrote_d = !transfer_ack_n && (wrote_q || (!mem_select_out_n && !write_n));
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wrote_q <= 1'b0;
        end else begin
            wrote_q <= wrote_d;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_wide_first;
        !mem_select_out_n[*4] ##1 mem_select_out_n;
    endsequence
    sequence s_wide_next;
        !mem_select_out_n[*2] ##1 mem_select_out_n;
    endsequence
    sequence s_narrow_rest;
        !mem_select_out_n[*5] ##1 mem_select_out_n;
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_grant_needs_req: assert property (!transfer_grant_n |-> !$past(transfer_request_n))
        else $error("grant without request");
    a_ack_after_grant: assert property ($fell(transfer_ack_n) |-> !$past(transfer_grant_n))
        else $error("acknowledge before grant");
    a_req_held: assert property (!transfer_request_n && transfer_grant_n |=> !transfer_request_n)
        else $error("request dropped before grant");
    a_grant_in_time: assert property ($fell(transfer_request_n) |-> ##[1:GRANT_LIM] !transfer_grant_n)
        else $error("grant too late");
    a_sel_in_ack: assert property (!mem_select_out_n |-> !transfer_ack_n && !io_strobe_n)
        else $error("select outside acknowledge or strobe mismatch");
    a_first_len: assert property ($fell(transfer_ack_n) && narrow_ram_select_n_i
        |=> mem_select_out_n ##1 s_wide_first)
        else $error("first transfer length wrong");
    a_next_len: assert property ($fell(mem_select_out_n) && !$past(mem_select_out_n, 2)
        && narrow_ram_select_n_i |=> s_wide_next)
        else $error("later transfer length wrong");
    a_narrow_len: assert property ($fell(mem_select_out_n) && !narrow_ram_select_n_i
        ##1 !mem_select_in_n |=> s_narrow_rest)
        else $error("narrow internal transfer length wrong");
    a_decode_sel: assert property (!mem_select_out_n && !$past(mem_select_out_n)
        && !$past(mem_select_out_n, 2) |-> mem_select_in_n == (addr >= srdma_pkg::INT_RAM_WORDS))
        else $error("ram decode answer wrong");
    a_reads_first: assert property (!mem_select_out_n && wrote_q |-> !write_n)
        else $error("read after write in burst");
    a_rel_last: assert property ($rose(transfer_request_n) |-> $rose(transfer_ack_n)
        && $rose(mem_select_out_n))
        else $error("release not with last transfer");
endmodule
`default_nettype wire

// ===== dv/srdma_tb.sv
// self-checking bench: sequencer and host ends joined by the link
`default_nettype none
module srdma_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    localparam logic [15:0] KEY = 16'hA5A5;
    logic mclk_i, sys_rst_i, job_valid, job_burst, buffered, narrow_n, wr_valid, busy_hold;
    logic busy, use_io, job_ready, wr_ready, rd_valid, done, err, we, re, late;
    logic [3:0] job_reads, job_writes;
    logic [15:0] job_addr, wr_data, rd_data, mem_addr, mem_wdata, mem_rdata;
    srdma_pkg::srdma_mode_t mode;
    int fail_count, n_tests, n_done, n_err, n_late, n_req;
    integer seed;
    logic [31:0] wexp[$];
    logic [15:0] rexp[$];
    logic [15:0] raexp[$];
    logic [15:0] fifo_q[$];
    srdma_if link();
    srdma_dev i_srdma_dev (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link(link.dev),
        .job_valid_i(job_valid), .job_ready_o(job_ready), .job_burst_i(job_burst),
        .job_reads_i(job_reads), .job_writes_i(job_writes), .job_addr_i(job_addr),
        .mode_i(mode), .buffered_i(buffered), .narrow_ram_select_n_i(narrow_n),
        .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .wr_data_i(wr_data),
        .rd_valid_o(rd_valid), .rd_data_o(rd_data), .done_o(done), .err_o(err));
    srdma_host i_srdma_host (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link(link.host),
        .bus_busy_i(busy), .use_io_strobe_i(use_io), .mem_addr_o(mem_addr),
        .mem_wdata_o(mem_wdata), .mem_we_o(we), .mem_re_o(re), .mem_rdata_i(mem_rdata),
        .grant_late_o(late));
    srdma_chk i_srdma_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .narrow_ram_select_n_i(narrow_n), .transfer_request_n(link.transfer_request_n),
        .transfer_grant_n(link.transfer_grant_n), .transfer_ack_n(link.transfer_ack_n),
        .mem_select_out_n(link.mem_select_out_n), .mem_select_in_n(link.mem_select_in_n),
        .io_strobe_n(link.io_strobe_n), .write_n(link.write_n), .addr(link.addr));
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    // ----------------------------------------
    // checking and host side stimulus
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(negedge mclk_i) begin
        mem_rdata <= mem_addr ^ KEY;
        busy <= busy_hold | (($random(seed) & 32'h3) == 0);
    end
    always @(posedge mclk_i) begin
        if (we) begin
            check({mem_addr, mem_wdata}, wexp.pop_front());
        end
        if (rd_valid) begin
            check({16'h0000, rd_data}, {16'h0000, rexp.pop_front()});
        end
        if (re) begin
            check({16'h0000, mem_addr}, {16'h0000, raexp.pop_front()});
        end
        n_done += int'(done);
        n_err += int'(err);
        n_late += int'(late);
        n_req += int'(buffered && !link.transfer_request_n);
    end
    function automatic logic [15:0] ext();
        return 16'h1000 | (16'($random(seed)) & 16'h0FFF);
    endfunction
    // notes every expected word, offers the job, then waits for its end
    task automatic job(input logic b, input logic [3:0] r, input logic [3:0] w,
        input logic [15:0] a, input logic [1:0] m, input logic exp_err);
        int nd, ne, k, nr, nw;
        logic [15:0] ad;
        nd = n_done;
        ne = n_err;
        nr = b ? int'(r) : int'(w == 4'h0);
        nw = b ? int'(w) : int'(w != 4'h0);
        for (k = 0; k < nr + nw && !exp_err; k++) begin
            ad = a + 16'(k);
            if (k < nr && !buffered) begin
                rexp.push_back(ad ^ KEY);
                if (ad >= srdma_pkg::INT_RAM_WORDS) begin
                    raexp.push_back(ad);
                end
            end else if (k >= nr && ad >= srdma_pkg::INT_RAM_WORDS) begin
                wexp.push_back({ad, fifo_q.pop_front()});
            end else if (k >= nr) begin
                void'(fifo_q.pop_front());
            end
        end
        for (k = 0; k < 50 && !job_ready; k++) @(negedge mclk_i);
        job_burst = b;
        job_reads = r;
        job_writes = w;
        job_addr = a;
        mode = srdma_pkg::srdma_mode_t'(m);
        job_valid = 1'b1;
        @(negedge mclk_i);
        job_valid = 1'b0;
        for (k = 0; k < 2000 && n_done == nd && n_err == ne; k++) @(negedge mclk_i);
        check(32'(n_err - ne), 32'(exp_err));
        check(32'(n_done - nd), 32'(!exp_err));
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        int k;
        seed = 56060;
        {job_valid, job_burst, buffered, wr_valid, busy_hold, use_io} = '0;
        {job_reads, job_writes, job_addr, wr_data} = '0;
        mode = srdma_pkg::SRDMA_MODE_BC;
        narrow_n = 1'b1;
        sys_rst_i = 1'b1;
        repeat (5) @(negedge mclk_i);
        sys_rst_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        for (k = 0; k < 40 && wr_ready; k++) begin
            wr_valid = 1'b1;
            wr_data = 16'($random(seed));
            fifo_q.push_back(wr_data);
            @(negedge mclk_i);
        end
        wr_valid = 1'b0;
        check(32'(k), 32'(srdma_pkg::FIFO_DEPTH));
        for (k = 0; k < 4; k++) begin
            job(1'b0, 4'h0, 4'h1, ext(), 2'(k), 1'b0);
            job(1'b0, 4'h0, 4'h0, ext(), 2'(k), 1'b0);
        end
        job(1'b1, 4'h2, 4'h2, ext(), 2'h1, 1'b0);
        n_late = 0;
        busy_hold = 1'b1;
        job(1'b1, 4'h5, 4'h4, ext(), 2'h0, 1'b0);
        busy_hold = 1'b0;
        check(32'(n_late), 32'h1);
        job(1'b1, 4'h1, 4'h1, ext(), 2'h3, 1'b1);
        use_io = 1'b1;
        job(1'b1, 4'h0, 4'h0, ext(), 2'h2, 1'b0);
        buffered = 1'b1;
        job(1'b1, 4'h3, 4'h0, ext(), 2'h1, 1'b0);
        buffered = 1'b0;
        use_io = 1'b0;
        check(32'(n_req), 32'h0);
        // strap passes a synchroniser, so let it settle while idle
        narrow_n = 1'b0;
        repeat (5) @(negedge mclk_i);
        job(1'b1, 4'h0, 4'h2, 16'h0010, 2'h0, 1'b0);
        job(1'b0, 4'h0, 4'h0, ext(), 2'h0, 1'b0);
        narrow_n = 1'b1;
        repeat (5) @(negedge mclk_i);
        use_io = 1'b1;
        job(1'b1, 4'h0, 4'hF, ext(), 2'h1, 1'b0);
        use_io = 1'b0;
        job(1'b1, 4'h4, 4'h5, ext(), 2'h0, 1'b0);
        check(32'(wexp.size() + rexp.size() + raexp.size() + fifo_q.size()), 32'h0);
        check({31'h0, wr_ready}, 32'h1);
        tally_and_finish();
    end
    // about twenty jobs of a few hundred cycles at most
    initial begin
        repeat (30000) @(posedge mclk_i);
        fail_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
